/* hdl/tpcs_consts.svh */
// Register map, field positions, reset values and clock-select codes
`ifndef TPCS_CONSTS_SVH
`define TPCS_CONSTS_SVH
`define TPCS_OFS_FLAGS 8'h00
`define TPCS_OFS_GCTRL 8'h01
`define TPCS_OFS_T0CTL 8'h02
`define TPCS_OFS_T1CTL 8'h03
`define TPCS_OFS_IRQEN 8'h04
`define TPCS_OFS_CMPA 8'h05
`define TPCS_OFS_CNT0 8'h06
`define TPCS_BIT_CMP 1
`define TPCS_BIT_OVF 0
`define TPCS_BIT_TSM 7
`define TPCS_BIT_PSRA 1
`define TPCS_BIT_PSRS 0
`define TPCS_BIT_PC 3
`define TPCS_CS_STOP 3'h0
`define TPCS_CS_DIV1 3'h1
`define TPCS_CS_DIV8 3'h2
`define TPCS_CS_DIV64 3'h3
`define TPCS_CS_DIV256 3'h4
`define TPCS_CS_DIV1024 3'h5
`define TPCS_CS_EXTFALL 3'h6
`define TPCS_CS_EXTRISE 3'h7
`define TPCS_CNT_MAX 8'hFF
`define TPCS_CNT_BOTTOM 8'h00
`define TPCS_RST_BYTE 8'h00
`define TPCS_RST_PSC 10'h000
`endif

/* hdl/tpcs_pkg.sv */
// Types for the timer prescaler and clock select block
package tpcs_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tpcs_bus_req_t;

    typedef struct packed {
        logic [1:0] flags;
        logic sync_hold_mode;
        logic shared_prescaler_reset;
        logic async_prescaler_reset;
        logic [2:0] cs0;
        logic [2:0] cs1;
        logic phase_correct;
        logic [1:0] irq_en;
        logic [7:0] compare_a_value;
        logic [7:0] cnt0;
        logic dir_down;
        logic [9:0] psc;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] pin_s3;
        logic [1:0] tick;
        logic [7:0] rd_data;
        logic cmp_irq;
        logic ovf_irq;
    } tpcs_state_t;
endpackage

/* hdl/tpcs_top.sv */
// Shared prescaler, clock select and timer0 event flags
`include "tpcs_consts.svh"

// Overview of operation
// - Compare-A flag sets when timer0 counter equals compare-A value on a tick.
// - Compare-A flag clears on vector acknowledge or on software writing one.
// - Compare-A request only when global enable, its enable and flag are set.
// - Overflow flag sets on wrap; in phase-correct mode on turn at zero.
// - Overflow flag clears on vector acknowledge or on software writing one.
// - Overflow request only when global enable, its enable and flag are set.
// - Both timers share one prescaler, each with its own clock select.
// - Clock select one counts every system clock cycle while the shared prescaler reset bit is clear.
// - Prescaler taps give divide by 8, 64, 256 and 1024.
// - Prescaler runs freely, independent of clock select settings.
// - Prescaler reset restarts the prescaled period for both timers.
// - Each count pin is sampled every cycle, synchronised, then edge detected.
// - Synchroniser stages update on the rising system clock edge.
// - Select seven ticks on rising pin edges, six on falling edges.
// - Counter updates 2 to 3 cycles after a pin edge.
// - External pin edges bypass the prescaler and count undivided.
// - With sync hold mode set, prescaler reset bits keep written values.
// - Writing sync hold mode from one to zero clears both prescaler reset bits.
// - Shared prescaler reset bit resets prescaler, then self-clears unless held.
// - Clock select zero gives no ticks, so the timer stays still.
// - Select codes: stop, undivided, four taps, external falling, external rising.
module tpcs_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire tpcs_pkg::tpcs_bus_req_t bus_req,
    input wire logic global_irq_enable,
    input wire logic cmp_vector_ack,
    input wire logic ovf_vector_ack,
    input wire logic [1:0] external_count_pin,
    output logic [7:0] rd_data,
    output logic [1:0] timer_tick,
    output logic cmp_irq,
    output logic ovf_irq
);
    import tpcs_pkg::*;

    tpcs_state_t q;
    tpcs_state_t d;
    logic [3:0] tap;
    logic [1:0] sel_tick;
    logic [2:0] cs [2];
    logic halt;
    logic cmp_match;
    logic ovf_event;

    // Taps fire on the last count of each period, so a reset restarts every period
    assign tap[0] = &q.psc[2:0];
    assign tap[1] = &q.psc[5:0];
    assign tap[2] = &q.psc[7:0];
    assign tap[3] = &q.psc[9:0];
    assign cs[0] = q.cs0;
    assign cs[1] = q.cs1;
    // Held prescaler reset halts both timers, undivided and external ones too
    assign halt = q.shared_prescaler_reset;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sel
            logic rise;
            logic fall;
            // Edge taken between second and third stage; first stage feeds only the second
            assign rise = q.pin_s2[gi] & ~q.pin_s3[gi];
            assign fall = ~q.pin_s2[gi] & q.pin_s3[gi];
            always_comb begin
                case (cs[gi])
                    `TPCS_CS_STOP: sel_tick[gi] = 1'b0;
                    `TPCS_CS_DIV1: sel_tick[gi] = ~halt;
                    `TPCS_CS_DIV8: sel_tick[gi] = ~halt & tap[0];
                    `TPCS_CS_DIV64: sel_tick[gi] = ~halt & tap[1];
                    `TPCS_CS_DIV256: sel_tick[gi] = ~halt & tap[2];
                    `TPCS_CS_DIV1024: sel_tick[gi] = ~halt & tap[3];
                    `TPCS_CS_EXTFALL: sel_tick[gi] = ~halt & fall;
                    `TPCS_CS_EXTRISE: sel_tick[gi] = ~halt & rise;
                    default: sel_tick[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    assign cmp_match = sel_tick[0] && (q.cnt0 == q.compare_a_value);
    assign ovf_event = sel_tick[0] && (q.phase_correct
        ? (q.dir_down && q.cnt0 == `TPCS_CNT_BOTTOM)
        : (q.cnt0 == `TPCS_CNT_MAX));

    always_comb begin
        d = q;
        d.rd_data = `TPCS_RST_BYTE;
        // Synchroniser chain, one sample per system clock
        d.pin_s1 = external_count_pin;
        d.pin_s2 = q.pin_s1;
        d.pin_s3 = q.pin_s2;
        d.tick = sel_tick;
        // Prescaler never looks at clock select; only its reset bit stops it
        if (q.shared_prescaler_reset) begin
            d.psc = `TPCS_RST_PSC;
        end else begin
            d.psc = q.psc + 10'h001;
        end
        // Counter moves in the same cycle as the tick, keeping the pin delay short
        if (sel_tick[0]) begin
            if (!q.phase_correct) begin
                d.cnt0 = q.cnt0 + 8'h01;
            end else if (q.dir_down) begin
                if (q.cnt0 == `TPCS_CNT_BOTTOM) begin
                    d.dir_down = 1'b0;
                    d.cnt0 = q.cnt0 + 8'h01;
                end else begin
                    d.cnt0 = q.cnt0 - 8'h01;
                end
            end else if (q.cnt0 == `TPCS_CNT_MAX) begin
                d.dir_down = 1'b1;
                d.cnt0 = q.cnt0 - 8'h01;
            end else begin
                d.cnt0 = q.cnt0 + 8'h01;
            end
        end
        if (q.shared_prescaler_reset && !q.sync_hold_mode) begin
            d.shared_prescaler_reset = 1'b0;
        end
        if (cmp_vector_ack) begin
            d.flags[`TPCS_BIT_CMP] = 1'b0;
        end
        if (ovf_vector_ack) begin
            d.flags[`TPCS_BIT_OVF] = 1'b0;
        end
        if (bus_req.wr) begin
            case (bus_req.addr)
                `TPCS_OFS_FLAGS: begin
                    d.flags = q.flags & ~bus_req.wdata[1:0];
                end
                `TPCS_OFS_GCTRL: begin
                    d.sync_hold_mode = bus_req.wdata[`TPCS_BIT_TSM];
                    if (bus_req.wdata[`TPCS_BIT_TSM]) begin
                        d.shared_prescaler_reset = bus_req.wdata[`TPCS_BIT_PSRS];
                        d.async_prescaler_reset = bus_req.wdata[`TPCS_BIT_PSRA];
                    end else if (q.sync_hold_mode) begin
                        d.shared_prescaler_reset = 1'b0;
                        d.async_prescaler_reset = 1'b0;
                    end else begin
                        d.shared_prescaler_reset = bus_req.wdata[`TPCS_BIT_PSRS];
                        d.async_prescaler_reset = 1'b0;
                    end
                end
                `TPCS_OFS_T0CTL: begin
                    d.cs0 = bus_req.wdata[2:0];
                    d.phase_correct = bus_req.wdata[`TPCS_BIT_PC];
                end
                `TPCS_OFS_T1CTL: d.cs1 = bus_req.wdata[2:0];
                `TPCS_OFS_IRQEN: d.irq_en = bus_req.wdata[1:0];
                `TPCS_OFS_CMPA: d.compare_a_value = bus_req.wdata;
                `TPCS_OFS_CNT0: d.cnt0 = bus_req.wdata;
                default: d.rd_data = `TPCS_RST_BYTE;
            endcase
        end
        // Hardware set wins over any clear in the same cycle
        if (cmp_match) begin
            d.flags[`TPCS_BIT_CMP] = 1'b1;
        end
        if (ovf_event) begin
            d.flags[`TPCS_BIT_OVF] = 1'b1;
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                `TPCS_OFS_FLAGS: d.rd_data = {6'h00, q.flags};
                `TPCS_OFS_GCTRL: d.rd_data = {q.sync_hold_mode, 5'h00,
                    q.async_prescaler_reset, q.shared_prescaler_reset};
                `TPCS_OFS_T0CTL: d.rd_data = {4'h0, q.phase_correct, q.cs0};
                `TPCS_OFS_T1CTL: d.rd_data = {5'h00, q.cs1};
                `TPCS_OFS_IRQEN: d.rd_data = {6'h00, q.irq_en};
                `TPCS_OFS_CMPA: d.rd_data = q.compare_a_value;
                `TPCS_OFS_CNT0: d.rd_data = q.cnt0;
                default: d.rd_data = `TPCS_RST_BYTE;
            endcase
        end
        // Requests follow the flag next value, so they rise with the flag
        d.cmp_irq = global_irq_enable & d.irq_en[`TPCS_BIT_CMP]
            & d.flags[`TPCS_BIT_CMP];
        d.ovf_irq = global_irq_enable & d.irq_en[`TPCS_BIT_OVF]
            & d.flags[`TPCS_BIT_OVF];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd_data;
    assign timer_tick = q.tick;
    assign cmp_irq = q.cmp_irq;
    assign ovf_irq = q.ovf_irq;

    logic gie_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gie_q <= 1'b0;
        end else begin
            gie_q <= global_irq_enable;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_rise_seen;
        !q.pin_s2[0] ##1 q.pin_s2[0];
    endsequence

    cmp_flag_set_a: assert property (
        cmp_match |=> q.flags[`TPCS_BIT_CMP])
        else $error("compare flag not set on match");
    cmp_flag_clear_a: assert property (
        cmp_vector_ack && !cmp_match && !(bus_req.wr && bus_req.addr == `TPCS_OFS_FLAGS)
        |=> !q.flags[`TPCS_BIT_CMP])
        else $error("compare flag not cleared by acknowledge");
    cmp_irq_gate_a: assert property (
        cmp_irq == (gie_q && q.irq_en[`TPCS_BIT_CMP] && q.flags[`TPCS_BIT_CMP]))
        else $error("compare request does not follow its gates");
    ovf_wrap_a: assert property (
        sel_tick[0] && !q.phase_correct && q.cnt0 == `TPCS_CNT_MAX
        |=> q.flags[`TPCS_BIT_OVF] && q.cnt0 == `TPCS_CNT_BOTTOM)
        else $error("overflow flag not set on wrap");
    ovf_irq_gate_a: assert property (
        ovf_irq |-> q.flags[`TPCS_BIT_OVF] && q.irq_en[`TPCS_BIT_OVF])
        else $error("overflow request without flag and enable");
    psc_reset_zero_a: assert property (
        q.shared_prescaler_reset |=> q.psc == `TPCS_RST_PSC)
        else $error("prescaler not forced to zero");
    psr_self_clear_a: assert property (
        q.shared_prescaler_reset && !q.sync_hold_mode && !bus_req.wr
        |=> !q.shared_prescaler_reset)
        else $error("shared prescaler reset did not self-clear");
    sync_hold_keep_a: assert property (
        q.sync_hold_mode && !bus_req.wr |=> $stable(q.shared_prescaler_reset))
        else $error("prescaler reset changed in sync hold mode");
    ext_rise_tick_a: assert property (
        q.cs0 == `TPCS_CS_EXTRISE && !halt ##0 s_rise_seen ##0 !q.pin_s3[0]
        |=> timer_tick[0])
        else $error("no tick on rising pin edge");
    ovf_flag_clear_a: assert property (
        ovf_vector_ack && !ovf_event && !(bus_req.wr && bus_req.addr == `TPCS_OFS_FLAGS)
        |=> !q.flags[`TPCS_BIT_OVF])
        else $error("overflow flag not cleared by acknowledge");
    div1_tick_a: assert property (
        q.cs0 == `TPCS_CS_DIV1 && !halt |=> timer_tick[0])
        else $error("no tick on undivided clock select");
    sync_release_a: assert property (
        q.sync_hold_mode && bus_req.wr && bus_req.addr == `TPCS_OFS_GCTRL
        && !bus_req.wdata[`TPCS_BIT_TSM]
        |=> !q.shared_prescaler_reset && !q.async_prescaler_reset)
        else $error("prescaler reset bits not released");
    stopped_no_tick_a: assert property (
        q.cs0 == `TPCS_CS_STOP |=> !timer_tick[0] && $stable(q.cnt0) || $past(bus_req.wr))
        else $error("timer advanced with no clock source");
endmodule

/* testbench/timer_prescaler_clock_select_test.sv */
// Self-checking bench for the prescaler, clock select and timer0 flags
`include "tpcs_consts.svh"
module timer_prescaler_clock_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tpcs_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    tpcs_bus_req_t bus_req = '0;
    logic gie = 1'b0;
    logic cack = 1'b0;
    logic oack = 1'b0;
    logic en = 1'b0;
    logic [7:0] rd_data;
    logic [7:0] v;
    logic [1:0] timer_tick;
    logic [1:0] pin;
    logic cmp_irq;
    logic ovf_irq;
    int rises, falls, t0, t1, r0, f0, i;
    int mismatches = 0;
    int check_count = 0;
    int ticks[2] = '{0, 0};
    int divs[$] = '{8, 64, 256, 1024};
    always #4 core_clk = ~core_clk;
    // Counted on the falling edge so the totals are settled at every rising edge
    always @(negedge core_clk) begin
        ticks[0] <= ticks[0] + timer_tick[0];
        ticks[1] <= ticks[1] + timer_tick[1];
    end
    tpcs_top tpcs_top_i (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
        .global_irq_enable(gie), .cmp_vector_ack(cack), .ovf_vector_ack(oack),
        .external_count_pin(pin), .rd_data(rd_data), .timer_tick(timer_tick),
        .cmp_irq(cmp_irq), .ovf_irq(ovf_irq));
    tpcs_pin_src tpcs_pin_src_i (.core_clk(core_clk), .en(en), .pin(pin),
        .rises(rises), .falls(falls));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        d = rd_data;
        @(posedge core_clk);
    endtask
    // Bounded wait for one of the two requests, sampled after the edge settles
    task automatic wait_irq(input logic ovf);
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge core_clk);
            #1;
            if ((ovf ? ovf_irq : cmp_irq) === 1'b1) break;
        end
        @(posedge core_clk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        wt(20000);
        mismatches++;
        final_report;
    end
    initial begin
        void'($urandom(62));
        wt(6);
        rst <= 1'b0;
        wt(1);
        // Reset values of every offset, 07 is unmapped
        for (i = 0; i < 8; i++) begin
            rd(i[7:0], v);
            chk({8'h00, v}, 16'h0000);
        end
        wr(`TPCS_OFS_T0CTL, {5'h00, `TPCS_CS_DIV1});
        t0 = ticks[0];
        wt(40);
        chk(16'(ticks[0] - t0), 16'h0028);
        wr(`TPCS_OFS_T0CTL, {5'h00, `TPCS_CS_STOP});
        wt(4);
        t0 = ticks[0];
        wt(40);
        chk(16'(ticks[0] - t0), 16'h0000);
        wr(`TPCS_OFS_GCTRL, 8'h81);
        wr(`TPCS_OFS_T0CTL, {5'h00, `TPCS_CS_DIV1});
        t0 = ticks[0];
        wt(20);
        chk(16'(ticks[0] - t0), 16'h0000);
        rd(`TPCS_OFS_GCTRL, v);
        chk({8'h00, v}, 16'h0081);
        wr(`TPCS_OFS_GCTRL, 8'h00);
        wt(2);
        t0 = ticks[0];
        wt(20);
        chk(16'(ticks[0] - t0), 16'h0014);
        rd(`TPCS_OFS_GCTRL, v);
        chk({8'h00, v}, 16'h0000);
        // Both timers on the same tap after a reset: one reset restarts both
        for (i = 0; i < 4; i++) begin
            wr(`TPCS_OFS_T0CTL, 8'h00);
            wr(`TPCS_OFS_T1CTL, 8'h00);
            wr(`TPCS_OFS_GCTRL, 8'h01);
            t0 = ticks[0];
            t1 = ticks[1];
            wr(`TPCS_OFS_T0CTL, 8'(i + 2));
            wr(`TPCS_OFS_T1CTL, 8'(i + 2));
            wt(divs[i] * 9 / 4);
            chk(16'(ticks[0] - t0), 16'h0002);
            chk(16'(ticks[1] - t1), 16'h0002);
        end
        wr(`TPCS_OFS_T0CTL, {5'h00, `TPCS_CS_EXTRISE});
        wr(`TPCS_OFS_T1CTL, {5'h00, `TPCS_CS_EXTFALL});
        wr(`TPCS_OFS_CNT0, 8'h00);
        t0 = ticks[0];
        t1 = ticks[1];
        r0 = rises;
        f0 = falls;
        en <= 1'b1;
        wt(300);
        en <= 1'b0;
        wt(10);
        chk(16'(ticks[0] - t0), 16'(rises - r0));
        chk(16'(ticks[1] - t1), 16'(falls - f0));
        rd(`TPCS_OFS_CNT0, v);
        chk({8'h00, v}, 16'(8'(rises - r0)));
        wr(`TPCS_OFS_T0CTL, 8'h00);
        wr(`TPCS_OFS_T1CTL, 8'h00);
        gie <= 1'b1;
        // Lower bound keeps the next match clear of the acknowledge window below
        wr(`TPCS_OFS_CMPA, 8'($urandom_range(8'hF0, 8'h40)));
        wr(`TPCS_OFS_IRQEN, 8'h03);
        wr(`TPCS_OFS_FLAGS, 8'h03);
        wr(`TPCS_OFS_CNT0, 8'h00);
        wr(`TPCS_OFS_T0CTL, {5'h00, `TPCS_CS_DIV1});
        wait_irq(1'b0);
        chk({15'h0000, cmp_irq}, 16'h0001);
        wr(`TPCS_OFS_FLAGS, 8'h02);
        rd(`TPCS_OFS_FLAGS, v);
        chk({15'h0000, v[1]}, 16'h0000);
        chk({15'h0000, cmp_irq}, 16'h0000);
        wait_irq(1'b1);
        chk({15'h0000, ovf_irq}, 16'h0001);
        oack <= 1'b1;
        wt(1);
        oack <= 1'b0;
        wt(1);
        #1;
        chk({15'h0000, ovf_irq}, 16'h0000);
        wt(1);
        gie <= 1'b0;
        wt(300);
        rd(`TPCS_OFS_FLAGS, v);
        chk({14'h0000, v[1:0]}, 16'h0003);
        chk({14'h0000, cmp_irq, ovf_irq}, 16'h0000);
        cack <= 1'b1;
        wt(1);
        cack <= 1'b0;
        wt(1);
        rd(`TPCS_OFS_FLAGS, v);
        chk({15'h0000, v[1]}, 16'h0000);
        wr(`TPCS_OFS_T0CTL, 8'h00);
        wr(`TPCS_OFS_FLAGS, 8'h03);
        wr(`TPCS_OFS_CNT0, 8'h10);
        wr(`TPCS_OFS_T0CTL, 8'h09);
        wt(300);
        rd(`TPCS_OFS_FLAGS, v);
        chk({15'h0000, v[0]}, 16'h0000);
        wt(250);
        rd(`TPCS_OFS_FLAGS, v);
        chk({15'h0000, v[0]}, 16'h0001);
        final_report;
    end
endmodule

/* testbench/tpcs_pin_src.sv */
// Model of the external signal source on the two count pins
module tpcs_pin_src (
    input wire logic core_clk,
    input wire logic en,
    output logic [1:0] pin,
    output int rises,
    output int falls
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold = 0;
    initial begin
        pin = 2'h0;
        rises = 0;
        falls = 0;
    end
    // Toggles only while enabled, so the pins are quiet whenever clock select changes
    always @(posedge core_clk) begin
        if (en) begin
            if (hold > 0) begin
                hold <= hold - 1;
            end else begin
                // Half period of 2 to 5 cycles stays under half the sampling rate
                hold <= $urandom_range(4, 1);
                pin <= ~pin;
                if (pin[0]) begin
                    falls <= falls + 1;
                end else begin
                    rises <= rises + 1;
                end
            end
        end
    end
endmodule
